//--- shared/asi_consts.svh
`ifndef ASI_CONSTS_SVH
`define ASI_CONSTS_SVH

`define ASI_A_DATA 3'h0
`define ASI_A_IER 3'h1
`define ASI_A_IIR 3'h2
`define ASI_A_MCR 3'h4
`define ASI_A_LSR 3'h5
`define ASI_A_MSR 3'h6
`define ASI_A_SCR 3'h7

`define ASI_IER_RX 0
`define ASI_IER_TX_HOLDING_EMPTY 1
`define ASI_IER_MS 3
`define ASI_MCR_DTR 0
`define ASI_MCR_RTS 1
`define ASI_LSR_DR 0
`define ASI_LSR_OE 1
`define ASI_LSR_FE 3
`define ASI_LSR_TX_HOLDING_EMPTY 5
`define ASI_LSR_TEMT 6

`define ASI_IER_RST 8'h00
`define ASI_MCR_RST 8'h00
`define ASI_SCR_RST 8'h00
`define ASI_PIN_IDLE 18'h3ffff

`define ASI_IIR_NONE 8'h01
`define ASI_IIR_RX 8'h04
`define ASI_IIR_TX_HOLDING_EMPTY 8'h02
`define ASI_IIR_MS 8'h00

`define ASI_BAUD_LAST 16'h0035
`define ASI_OVS_MID 4'h7
`define ASI_OVS_LAST 4'hf
`define ASI_TX_WAIT_LAST 4'h7
`define ASI_TX_HOLDING_EMPTY_AT 4'h7
`define ASI_BIT_LAST 3'h7

`define ASI_CLK_NS 10
`define ASI_CLR_NS 140
`define ASI_MCR_NS 100
`define ASI_MS_NS 170
`define ASI_CLR_CYC (`ASI_CLR_NS / `ASI_CLK_NS)
`define ASI_MCR_CYC (`ASI_MCR_NS / `ASI_CLK_NS)
`define ASI_MS_CYC (`ASI_MS_NS / `ASI_CLK_NS)

`endif

//--- shared/asi_pkg.sv
package asi_pkg;
    typedef logic [7:0] asi_byte_type;
    typedef enum logic [2:0] {
        ASI_RX_IDLE, ASI_RX_START, ASI_RX_DATA, ASI_RX_STOP, ASI_RX_PUSH
    } asi_rx_state_type;
    typedef enum logic [2:0] {
        ASI_TX_IDLE, ASI_TX_WAIT, ASI_TX_START, ASI_TX_DATA, ASI_TX_STOP
    } asi_tx_state_type;
endpackage : asi_pkg

//--- src/asi_buf2.sv
`timescale 1ns/1ns
`default_nettype none
module asi_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];
    logic [WIDTH-1:0] next_mem [2];
    logic wptr, rptr, next_wptr, next_rptr;
    logic [1:0] cnt, next_cnt;
    logic push, pop;

    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rptr];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_mem = mem;
        next_wptr = wptr;
        next_rptr = rptr;
        if (push) begin
            next_mem[wptr] = in_data;
            next_wptr = !wptr;
        end
        if (pop) begin
            next_rptr = !rptr;
        end
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wptr <= 1'b0;
            rptr <= 1'b0;
            cnt <= 2'h0;
        end else begin
            mem <= next_mem;
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt <= next_cnt;
        end
    end
endmodule : asi_buf2
`default_nettype wire

//--- src/asi_top.sv
// Behaviour
// R1 - Stop bit sampled raises receive interrupt one baud tick later
// R2 - Reading receive buffer or line status drops receive interrupt quickly
// R3 - First holding write starts start bit 8 to 24 ticks later
// R4 - Holding-empty interrupt rises 8 ticks after stop bit begins
// R5 - Writing transmit holding register clears holding-empty interrupt quickly
// R6 - Initial holding write raises holding-empty interrupt 16 to 32 ticks later
// R7 - Reading interrupt identity clears holding-empty interrupt quickly
// R8 - Modem control write updates RTS and DTR within 100 ns
// R9 - CTS, DSR or carrier change sets modem interrupt within 170 ns
// R10 - Reading modem status clears modem interrupt quickly
// R11 - One internal baud tick times both receiver and transmitter
// R12 - After reset interrupt identity reads 01, nothing pending
// R13 - Interrupt output high while any enabled condition pending
`timescale 1ns/1ns
`default_nettype none
`include "asi_consts.svh"
module asi_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic [2:0] addr,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire asi_pkg::asi_byte_type data_in,
    output asi_pkg::asi_byte_type data_out,
    output logic data_oe,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic carrier_detect_in_n,
    output logic rts_n,
    output logic dtr_n,
    output logic irq_out
);
    import asi_pkg::*;

    function automatic asi_byte_type asi_iir(input logic [2:0] act);
        if (act[0]) return `ASI_IIR_RX;
        else if (act[1]) return `ASI_IIR_TX_HOLDING_EMPTY;
        else if (act[2]) return `ASI_IIR_MS;
        else return `ASI_IIR_NONE;
    endfunction : asi_iir

    // Every pin except clk and rst_b passes two flops before use
    logic [17:0] sync1, sync2;
    logic cs_s, rd_s, wr_s, rxd_s;
    logic [2:0] addr_s, ms_s;
    asi_byte_type din_s;
    assign {cs_s, rd_s, wr_s, addr_s, din_s, ms_s, rxd_s} = sync2;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= `ASI_PIN_IDLE;
            sync2 <= `ASI_PIN_IDLE;
        end else begin
            sync1 <= {cs_b, host_read_strobe_n, host_write_strobe_n, addr,
                      data_in, cts_n, dsr_n, carrier_detect_in_n, serial_in};
            sync2 <= sync1;
        end
    end

    // Baud tick, 16 per bit
    logic [15:0] div, next_div;
    logic baud_tick, next_tick;
    always_comb begin
        next_tick = (div == `ASI_BAUD_LAST); // see R11
        next_div = next_tick ? 16'h0000 : div + 16'h0001;
    end

    // Receiver group
    asi_rx_state_type rx_state, next_rx_state;
    logic [3:0] rx_cnt, next_rx_cnt;
    logic [2:0] rx_idx, next_rx_idx;
    asi_byte_type rx_shift, next_rx_shift;
    logic rx_push, rx_stop_hit, ferr, next_ferr;
    logic buf_ready, buf_valid, buf_pop;
    asi_byte_type buf_data;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt;
        next_rx_idx = rx_idx;
        next_rx_shift = rx_shift;
        next_ferr = ferr;
        rx_push = 1'b0;
        rx_stop_hit = 1'b0;
        if (baud_tick) begin
            next_rx_cnt = rx_cnt + 4'h1;
            unique case (rx_state)
                ASI_RX_IDLE: begin
                    next_rx_cnt = 4'h0;
                    if (!rxd_s) next_rx_state = ASI_RX_START;
                end
                ASI_RX_START: begin
                    if (rx_cnt == `ASI_OVS_MID) begin
                        next_rx_cnt = 4'h0;
                        next_rx_idx = 3'h0;
                        next_rx_state = rxd_s ? ASI_RX_IDLE : ASI_RX_DATA;
                    end
                end
                ASI_RX_DATA: begin
                    if (rx_cnt == `ASI_OVS_LAST) begin
                        next_rx_shift = {rxd_s, rx_shift[7:1]};
                        next_rx_idx = rx_idx + 3'h1;
                        if (rx_idx == `ASI_BIT_LAST) next_rx_state = ASI_RX_STOP;
                    end
                end
                ASI_RX_STOP: begin
                    if (rx_cnt == `ASI_OVS_LAST) begin
                        rx_stop_hit = 1'b1;
                        next_ferr = ferr | !rxd_s;
                        next_rx_state = ASI_RX_PUSH;
                    end
                end
                ASI_RX_PUSH: begin
                    rx_push = 1'b1; // see R1
                    next_rx_state = ASI_RX_IDLE;
                end
            endcase
        end
    end

    // Two words of slack before overrun
    asi_buf2 #(.WIDTH(8)) u_rxbuf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(rx_push),
        .in_ready(buf_ready),
        .in_data(rx_shift),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(buf_data)
    );

    // Host strobe edges, taken at the end of each strobe
    logic rd_prev, wr_prev, sel, rd_end, wr_end, wr_thr;
    assign sel = !cs_s;
    assign rd_end = sel && rd_s && !rd_prev;
    assign wr_end = sel && wr_s && !wr_prev;
    assign wr_thr = wr_end && (addr_s == `ASI_A_DATA);
    assign buf_pop = rd_end && (addr_s == `ASI_A_DATA);

    // Transmitter group
    asi_tx_state_type tx_state, next_tx_state;
    logic [3:0] tx_cnt, next_tx_cnt;
    logic [2:0] tx_idx, next_tx_idx;
    asi_byte_type hold, next_hold, tx_shift, next_tx_shift;
    logic hold_full, next_hold_full, next_serial_out, tx_holding_empty_evt;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt = tx_cnt;
        next_tx_idx = tx_idx;
        next_hold = hold;
        next_hold_full = hold_full;
        next_tx_shift = tx_shift;
        next_serial_out = serial_out;
        tx_holding_empty_evt = 1'b0;
        if (baud_tick) begin
            next_tx_cnt = tx_cnt + 4'h1;
            unique case (tx_state)
                ASI_TX_IDLE: begin
                    next_tx_cnt = 4'h0;
                    if (hold_full) next_tx_state = ASI_TX_WAIT;
                end
                ASI_TX_WAIT: begin
                    if (tx_cnt == `ASI_TX_WAIT_LAST) begin // see R3
                        next_tx_state = ASI_TX_START;
                        next_tx_cnt = 4'h0;
                        next_tx_shift = hold;
                        next_hold_full = 1'b0;
                        next_serial_out = 1'b0;
                    end
                end
                ASI_TX_START: begin
                    tx_holding_empty_evt = (tx_cnt == `ASI_TX_HOLDING_EMPTY_AT) && !hold_full; // see R6
                    if (tx_cnt == `ASI_OVS_LAST) begin
                        next_tx_state = ASI_TX_DATA;
                        next_tx_idx = 3'h0;
                        next_serial_out = tx_shift[0];
                    end
                end
                ASI_TX_DATA: begin
                    if (tx_cnt == `ASI_OVS_LAST) begin
                        next_tx_idx = tx_idx + 3'h1;
                        next_tx_shift = {1'b0, tx_shift[7:1]};
                        next_serial_out = tx_shift[1];
                        if (tx_idx == `ASI_BIT_LAST) begin
                            next_tx_state = ASI_TX_STOP;
                            next_serial_out = 1'b1;
                        end
                    end
                end
                ASI_TX_STOP: begin
                    tx_holding_empty_evt = (tx_cnt == `ASI_TX_HOLDING_EMPTY_AT) && !hold_full; // see R4
                    if (tx_cnt == `ASI_OVS_LAST) begin
                        next_tx_state = hold_full ? ASI_TX_START : ASI_TX_IDLE;
                        next_tx_shift = hold;
                        next_hold_full = 1'b0;
                        next_serial_out = !hold_full;
                    end
                end
            endcase
        end
        // A late write overrides a same-cycle transfer: word kept
        if (wr_thr) begin
            next_hold = din_s;
            next_hold_full = 1'b1;
        end
    end

    // Host register and interrupt group
    asi_byte_type ier, next_ier, modem_control_reg, next_mcr, scr, next_scr;
    asi_byte_type next_dout, line_status_reg, modem_status_reg, iir_now;
    logic [2:0] ms_prev, ms_delta, next_ms_delta;
    logic rx_pend, tx_holding_empty_pend, ms_pend, overrun;
    logic next_rx_pend, next_tx_holding_empty_pend, next_overrun, next_irq;
    logic [2:0] act;

    assign ms_pend = |ms_delta;
    assign act = {ms_pend & ier[`ASI_IER_MS], tx_holding_empty_pend & ier[`ASI_IER_TX_HOLDING_EMPTY],
                  rx_pend & ier[`ASI_IER_RX]};
    assign iir_now = asi_iir(act);
    assign line_status_reg = {1'b0, !hold_full && (tx_state == ASI_TX_IDLE), !hold_full,
                  1'b0, ferr, 1'b0, overrun, buf_valid};
    assign modem_status_reg = {!ms_s[0], 1'b0, !ms_s[1], !ms_s[2], ms_delta[0], 1'b0,
                  ms_delta[1], ms_delta[2]};

    always_comb begin
        next_ier = ier;
        next_mcr = modem_control_reg;
        next_scr = scr;
        if (wr_end && addr_s == `ASI_A_IER) next_ier = din_s;
        if (wr_end && addr_s == `ASI_A_MCR) next_mcr = din_s; // see R8
        if (wr_end && addr_s == `ASI_A_SCR) next_scr = din_s;
        unique case (addr_s)
            `ASI_A_DATA: next_dout = buf_data;
            `ASI_A_IER: next_dout = ier;
            `ASI_A_IIR: next_dout = iir_now; // see R12
            `ASI_A_MCR: next_dout = modem_control_reg;
            `ASI_A_LSR: next_dout = line_status_reg;
            `ASI_A_MSR: next_dout = modem_status_reg;
            `ASI_A_SCR: next_dout = scr;
            default: next_dout = 8'h00;
        endcase
        // Set beats clear on every flag
        next_rx_pend = (rx_pend && !(rd_end && (addr_s == `ASI_A_DATA
            || addr_s == `ASI_A_LSR))) || rx_push; // see R2
        next_tx_holding_empty_pend = (tx_holding_empty_pend && !wr_thr // see R5
            && !(rd_end && addr_s == `ASI_A_IIR
                 && iir_now == `ASI_IIR_TX_HOLDING_EMPTY)) || tx_holding_empty_evt; // see R7
        next_overrun = (overrun && !(rd_end && addr_s == `ASI_A_LSR))
            || (rx_push && !buf_ready);
        next_ms_delta = ((rd_end && addr_s == `ASI_A_MSR) ? 3'h0 // see R10
            : ms_delta) | (ms_s ^ ms_prev); // see R9
        next_irq = |{next_ms_delta & {3{next_ier[`ASI_IER_MS]}},
                     next_tx_holding_empty_pend & next_ier[`ASI_IER_TX_HOLDING_EMPTY],
                     next_rx_pend & next_ier[`ASI_IER_RX]}; // see R13
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div <= 16'h0000;
            baud_tick <= 1'b0;
            rx_state <= ASI_RX_IDLE;
            rx_cnt <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= 8'h00;
            ferr <= 1'b0;
            tx_state <= ASI_TX_IDLE;
            tx_cnt <= 4'h0;
            tx_idx <= 3'h0;
            hold <= 8'h00;
            hold_full <= 1'b0;
            tx_shift <= 8'h00;
            serial_out <= 1'b1;
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
            ier <= `ASI_IER_RST;
            modem_control_reg <= `ASI_MCR_RST;
            scr <= `ASI_SCR_RST;
            data_out <= 8'h00;
            data_oe <= 1'b0;
            rx_pend <= 1'b0;
            tx_holding_empty_pend <= 1'b0;
            overrun <= 1'b0;
            ms_prev <= 3'h7;
            ms_delta <= 3'h0;
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            irq_out <= 1'b0;
        end else begin
            div <= next_div;
            baud_tick <= next_tick;
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            rx_idx <= next_rx_idx;
            rx_shift <= next_rx_shift;
            // Set beats clear: a framing error in the clearing cycle stays
            ferr <= (rd_end && addr_s == `ASI_A_LSR) ? (rx_stop_hit && !rxd_s)
                : next_ferr;
            tx_state <= next_tx_state;
            tx_cnt <= next_tx_cnt;
            tx_idx <= next_tx_idx;
            hold <= next_hold;
            hold_full <= next_hold_full;
            tx_shift <= next_tx_shift;
            serial_out <= next_serial_out;
            rd_prev <= rd_s;
            wr_prev <= wr_s;
            ier <= next_ier;
            modem_control_reg <= next_mcr;
            scr <= next_scr;
            data_out <= next_dout;
            data_oe <= sel && !rd_s;
            rx_pend <= next_rx_pend;
            tx_holding_empty_pend <= next_tx_holding_empty_pend;
            overrun <= next_overrun;
            ms_prev <= ms_s;
            ms_delta <= next_ms_delta;
            rts_n <= !next_mcr[`ASI_MCR_RTS];
            dtr_n <= !next_mcr[`ASI_MCR_DTR];
            irq_out <= next_irq;
        end
    end

    // Checking helpers: ticks since the last holding write
    localparam int CLR_CYC = `ASI_CLR_CYC;
    localparam int MS_CYC = `ASI_MS_CYC;
    localparam int TICK_CYC = int'(`ASI_BAUD_LAST) + 1;
    logic [5:0] since_wr;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) since_wr <= 6'h3f;
        else if (wr_thr) since_wr <= 6'h00;
        else if (baud_tick && since_wr != 6'h3f) since_wr <= since_wr + 6'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_RX_IRQ: assert property ( // see R1
        rx_stop_hit |-> ##TICK_CYC rx_push
        ##1 (rx_pend && (irq_out || !ier[`ASI_IER_RX])))
        else $error("receive flag not set one tick after stop");
    AST_RX_CLR: assert property ( // see R2
        rd_end && addr_s == `ASI_A_LSR && !rx_push |-> ##[1:CLR_CYC] !rx_pend)
        else $error("receive flag not cleared by status read");
    AST_TX_START: assert property ( // see R3
        tx_state == ASI_TX_START && $past(tx_state) == ASI_TX_WAIT
        |-> since_wr >= 6'h08 && since_wr <= 6'h18)
        else $error("start bit outside 8 to 24 ticks");
    AST_TX_HOLDING_EMPTY_STOP: assert property ( // see R4
        baud_tick && tx_state == ASI_TX_STOP && tx_cnt == `ASI_TX_HOLDING_EMPTY_AT
        && !hold_full && !wr_thr |=> tx_holding_empty_pend)
        else $error("holding-empty flag missing in stop bit");
    AST_THR_CLR: assert property ( // see R5
        wr_thr && !tx_holding_empty_evt |=> !tx_holding_empty_pend)
        else $error("holding write left flag set");
    AST_TX_HOLDING_EMPTY_INIT: assert property ( // see R6
        $rose(tx_holding_empty_pend) && tx_state == ASI_TX_START
        |-> since_wr >= 6'h10 && since_wr <= 6'h20)
        else $error("initial holding-empty outside 16 to 32 ticks");
    AST_IIR_CLR: assert property ( // see R7
        rd_end && addr_s == `ASI_A_IIR && iir_now == `ASI_IIR_TX_HOLDING_EMPTY
        && !tx_holding_empty_evt |=> !tx_holding_empty_pend)
        else $error("identity read left holding-empty set");
    AST_MCR: assert property ( // see R8
        wr_end && addr_s == `ASI_A_MCR
        |=> rts_n == !$past(din_s[1]) && dtr_n == !$past(din_s[0]))
        else $error("modem outputs not updated");
    AST_MS_SET: assert property ( // see R9
        $changed({cts_n, dsr_n, carrier_detect_in_n})
        |-> ##[1:MS_CYC] ms_pend)
        else $error("modem change not flagged in time");
    AST_MS_CLR: assert property ( // see R10
        rd_end && addr_s == `ASI_A_MSR && ms_s == ms_prev |=> !ms_pend)
        else $error("modem status read left flag set");
    AST_IDLE_ID: assert property ( // see R12
        act == 3'h0 |-> iir_now == `ASI_IIR_NONE)
        else $error("identity not idle with nothing pending");
    AST_IRQ: assert property ( // see R13
        irq_out == |act)
        else $error("interrupt output disagrees with pending set");

    COV_RX: cover property (rx_push ##[1:1000] rd_end);
    COV_TX: cover property (wr_thr ##[1:1000] $rose(tx_holding_empty_pend));
    COV_OVR: cover property (rx_push && !buf_ready);
    COV_MS: cover property ($rose(ms_pend) ##[1:100] !ms_pend);
endmodule : asi_top
`default_nettype wire

//--- verification/asi_modem_model.sv
`timescale 1ns/1ns
`default_nettype none
module asi_modem_model #(
    parameter int BIT_CYC = 864
) (
    input wire logic clk,
    input wire logic serial_out,
    output var logic serial_in,
    output var logic cts_n,
    output var logic dsr_n,
    output var logic carrier_detect_in_n
);
    logic [7:0] rx_byte;
    logic rx_stop;
    int rx_count;

    initial begin
        serial_in = 1'b1;
        cts_n = 1'b1;
        dsr_n = 1'b1;
        carrier_detect_in_n = 1'b1;
    end

    // Line rests high between frames, as a real driver does
    task send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            serial_in <= frame[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
    endtask : send_byte

    task set_pin(input int idx, input logic v);
        @(posedge clk);
        case (idx)
            0: cts_n <= v;
            1: dsr_n <= v;
            default: carrier_detect_in_n <= v;
        endcase
    endtask : set_pin

    // Mid-bit sampling tolerates a few clocks of skew on the edges
    initial begin
        rx_count = 0;
        rx_byte = 8'h00;
        rx_stop = 1'b0;
        forever begin
            @(negedge serial_out);
            repeat (BIT_CYC / 2) @(posedge clk);
            if (serial_out === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge clk);
                    rx_byte[i] = serial_out;
                end
                repeat (BIT_CYC) @(posedge clk);
                rx_stop = serial_out;
                rx_count++;
            end
        end
    end
endmodule : asi_modem_model
`default_nettype wire

//--- verification/tb_async_serial_irq_timing.sv
`timescale 1ns/1ns
`default_nettype none
`include "asi_consts.svh"
module tb_async_serial_irq_timing;
    import asi_pkg::*;
    localparam int TICK = int'(`ASI_BAUD_LAST) + 1;
    localparam int BIT = 16 * TICK;
    logic clk, rst_b, cs_b, host_read_strobe_n, host_write_strobe_n;
    logic [2:0] addr;
    asi_byte_type data_in, data_out, rd;
    logic data_oe, serial_in, serial_out, cts_n, dsr_n, carrier_detect_in_n;
    logic rts_n, dtr_n, irq_out;
    int n_fail, n_tests, cyc, t_rise;

    asi_top dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .addr(addr),
        .host_read_strobe_n(host_read_strobe_n),
        .host_write_strobe_n(host_write_strobe_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .serial_in(serial_in),
        .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
        .carrier_detect_in_n(carrier_detect_in_n), .rts_n(rts_n),
        .dtr_n(dtr_n), .irq_out(irq_out));

    asi_modem_model #(.BIT_CYC(BIT)) modem (.clk(clk),
        .serial_out(serial_out), .serial_in(serial_in), .cts_n(cts_n),
        .dsr_n(dsr_n), .carrier_detect_in_n(carrier_detect_in_n));

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : chk

    // Strobes pass two sync flops, so both phases stay 8 clocks or longer
    task host_wr(input logic [2:0] a, input asi_byte_type d);
        @(posedge clk);
        cs_b <= 1'b0;
        addr <= a;
        data_in <= d;
        repeat (2) @(posedge clk);
        host_write_strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        host_write_strobe_n <= 1'b1;
        t_rise = cyc;
        repeat (5) @(posedge clk);
        cs_b <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : host_wr

    task host_rd(input logic [2:0] a, output asi_byte_type d);
        @(posedge clk);
        cs_b <= 1'b0;
        addr <= a;
        repeat (2) @(posedge clk);
        host_read_strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        d = data_out;
        chk("read drive", 8'h01, {7'h00, data_oe});
        @(posedge clk);
        host_read_strobe_n <= 1'b1;
        repeat (5) @(posedge clk);
        cs_b <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : host_rd

    task wait_sig(input int which, input logic lvl, input int lim);
        int n;
        n = 0;
        while (((which == 0) ? irq_out : serial_out) !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_sig

    task test_reset;
        chk("reset outputs", 8'h0e,
            {3'h0, data_oe, serial_out, rts_n, dtr_n, irq_out});
        chk("reset data", 8'h00, data_out);
        host_rd(`ASI_A_IIR, rd);
        chk("iir after reset", `ASI_IIR_NONE, rd);
        host_rd(`ASI_A_LSR, rd);
        chk("lsr after reset", 8'h60, rd);
        host_rd(3'h3, rd);
        chk("unmapped read", 8'h00, rd);
    endtask : test_reset

    task test_mcr;
        logic [1:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 2'h3 - i[1:0];
            host_wr(`ASI_A_MCR, {6'h00, v});
            chk("modem outputs", {6'h00, ~v}, {6'h00, rts_n, dtr_n});
        end
    endtask : test_mcr

    task test_modem;
        logic [7:0] mask;
        host_wr(`ASI_A_IER, 8'h08);
        for (int i = 0; i < 3; i++) begin
            mask = (i == 2) ? 8'h08 : (8'h01 << i);
            modem.set_pin(i, 1'b0);
            repeat (16) @(posedge clk);
            @(negedge clk);
            chk("modem irq set", 8'h01, {7'h00, irq_out});
            host_rd(`ASI_A_IIR, rd);
            chk("iir modem", `ASI_IIR_MS, rd);
            host_rd(`ASI_A_MSR, rd);
            chk("msr delta", mask, rd & 8'h0f);
            chk("modem irq clear", 8'h00, {7'h00, irq_out});
        end
    endtask : test_modem

    task test_tx;
        int t0, ts, tp;
        host_wr(`ASI_A_IER, 8'h02);
        host_rd(`ASI_A_IIR, rd);
        chk("irq idle", 8'h00, {7'h00, irq_out});
        host_wr(`ASI_A_DATA, 8'h35);
        t0 = t_rise;
        wait_sig(1, 1'b0, 30 * BIT);
        ts = cyc;
        chk("start delay", 8'h01, {7'h00, (ts - t0 >= 8 * TICK) &&
            (ts - t0 <= 24 * TICK + 4)});
        wait_sig(0, 1'b1, 40 * TICK);
        chk("tx_holding_empty delay", 8'h01, {7'h00, (cyc - t0 >= 16 * TICK) &&
            (cyc - t0 <= 32 * TICK + 4)});
        host_rd(`ASI_A_IIR, rd);
        chk("iir tx_holding_empty", `ASI_IIR_TX_HOLDING_EMPTY, rd);
        chk("tx_holding_empty clear by iir", 8'h00, {7'h00, irq_out});
        while (cyc < ts + 9 * BIT - 50) @(posedge clk);
        wait_sig(1, 1'b1, 100);
        tp = cyc;
        wait_sig(0, 1'b1, 10 * TICK);
        chk("stop to irq", 8'h01, {7'h00, (cyc - tp >= 8 * TICK - 2) &&
            (cyc - tp <= 8 * TICK + 3)});
        host_wr(`ASI_A_DATA, 8'hc4);
        chk("tx_holding_empty clear by write", 8'h00, {7'h00, irq_out});
        chk("tx byte", 8'h35, modem.rx_byte);
        chk("tx stop", 8'h01, {7'h00, modem.rx_stop});
        chk("tx frames", 8'h01, modem.rx_count[7:0]);
    endtask : test_tx

    task test_rx;
        host_wr(`ASI_A_IER, 8'h09);
        modem.send_byte(8'ha6);
        wait_sig(0, 1'b1, 2 * TICK);
        chk("rx irq", 8'h01, {7'h00, irq_out});
        host_rd(`ASI_A_IIR, rd);
        chk("iir rx", `ASI_IIR_RX, rd);
        host_rd(`ASI_A_LSR, rd);
        chk("data ready", 8'h01, {7'h00, rd[0]});
        chk("rx clear by lsr", 8'h00, {7'h00, irq_out});
        host_rd(`ASI_A_DATA, rd);
        chk("rx byte", 8'ha6, rd);
        // Third word meets a full buffer and must be refused
        modem.send_byte(8'h11);
        modem.send_byte(8'h22);
        modem.send_byte(8'h33);
        wait_sig(0, 1'b1, 2 * TICK);
        modem.set_pin(1, 1'b1);
        repeat (16) @(posedge clk);
        host_rd(`ASI_A_MSR, rd);
        chk("irq held by rx", 8'h01, {7'h00, irq_out});
        host_rd(`ASI_A_DATA, rd);
        chk("first kept", 8'h11, rd);
        chk("rx clear by read", 8'h00, {7'h00, irq_out});
        host_rd(`ASI_A_LSR, rd);
        chk("overrun", 8'h01, {7'h00, rd[1]});
        host_rd(`ASI_A_DATA, rd);
        chk("second kept", 8'h22, rd);
        host_rd(`ASI_A_LSR, rd);
        chk("drained", 8'h00, {7'h00, rd[0]});
    endtask : test_rx

    task test_done;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        cs_b = 1'b1;
        addr = 3'h0;
        host_read_strobe_n = 1'b1;
        host_write_strobe_n = 1'b1;
        data_in = 8'h00;
        cyc = 0;
        n_fail = 0;
        n_tests = 0;
        t_rise = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        test_reset();
        test_mcr();
        test_modem();
        test_tx();
        test_rx();
        test_done();
    end

    // Whole run needs about 50k clocks
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule : tb_async_serial_irq_timing
`default_nettype wire
